// *** hdl/rcd_consts.vh ***
`ifndef RCD_CONSTS_VH
`define RCD_CONSTS_VH

`define RCD_IW 14
`define RCD_PCW 11
`define RCD_AW 7
`define RCD_DW 8

`define RCD_OSC_PER_CYCLE 3'h4
`define RCD_PH_Q1 2'h0
`define RCD_PH_Q2 2'h1
`define RCD_PH_Q3 2'h2
`define RCD_PH_Q4 2'h3

`define RCD_GRP_BYTE 2'h0
`define RCD_GRP_BIT 2'h1
`define RCD_GRP_LITCTL 2'h2

`define RCD_OP_MISC 4'h0
`define RCD_OP_CLR 4'h1
`define RCD_OP_SUBWF 4'h2
`define RCD_OP_DECF 4'h3
`define RCD_OP_IORWF 4'h4
`define RCD_OP_ANDWF 4'h5
`define RCD_OP_XORWF 4'h6
`define RCD_OP_ADDWF 4'h7
`define RCD_OP_MOVF 4'h8
`define RCD_OP_COMF 4'h9
`define RCD_OP_INCF 4'ha
`define RCD_OP_DECFSZ 4'hb
`define RCD_OP_RRF 4'hc
`define RCD_OP_RLF 4'hd
`define RCD_OP_SWAPF 4'he
`define RCD_OP_INCFSZ 4'hf

`define RCD_MISC_RETURN 7'h08
`define RCD_MISC_RETFIE 7'h09
`define RCD_MISC_SLEEP 7'h63
`define RCD_MISC_CLRWDT 7'h64

`define RCD_BOP_CLR 2'h0
`define RCD_BOP_SET 2'h1
`define RCD_BOP_TSTC 2'h2
`define RCD_BOP_TSTS 2'h3

`define RCD_LOP_IORLW 4'h8
`define RCD_LOP_ANDLW 4'h9
`define RCD_LOP_XORLW 4'ha
`define RCD_LOP_UNDEF 4'hb

`define RCD_ADDR_TIMER_ZERO 7'h01
`define RCD_ADDR_IO_PORT 7'h06

`define RCD_PC_RST 11'h000
`define RCD_W_RST 8'h00
`define RCD_INSTR_RST 14'h0000

`endif

// *** hdl/rcd_qphase.v ***
`timescale 1ns/1ns
`default_nettype none
`include "rcd_consts.vh"

module rcd_qphase (
   input wire clk,
   input wire reset_n,
   output wire [1:0] phase,
   output wire cycle_end
);
   reg [1:0] phase_reg;

   // one instruction cycle is four oscillator periods
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_reg <= `RCD_PH_Q1;
      end else begin
         phase_reg <= phase_reg + 2'h1;
      end
   end

   assign phase = phase_reg;
   assign cycle_end = (phase_reg == `RCD_PH_Q4);
endmodule

`default_nettype wire

// *** hdl/rcd_field_split.v ***
`timescale 1ns/1ns
`default_nettype none
`include "rcd_consts.vh"

module rcd_field_split (
   input wire [13:0] instr,
   output wire [1:0] group,
   output wire [3:0] byte_op,
   output wire dest,
   output wire [6:0] file_addr,
   output wire [2:0] bit_sel,
   output wire [1:0] bit_op,
   output wire [7:0] lit8,
   output wire [10:0] lit11,
   output wire [3:0] lit_op,
   output wire is_jump
);
   // top two bits pick the group; 10 and 11 are both literal/control
   assign group = (instr[13:12] == 2'h0) ? `RCD_GRP_BYTE :
                  (instr[13:12] == 2'h1) ? `RCD_GRP_BIT : `RCD_GRP_LITCTL;
   assign is_jump = ~instr[12];
   assign byte_op = instr[11:8];
   assign dest = instr[7];
   assign file_addr = instr[6:0];
   assign bit_op = instr[11:10];
   assign bit_sel = instr[9:7];
   assign lit_op = instr[11:8];
   assign lit8 = instr[7:0];
   assign lit11 = instr[10:0];
endmodule

`default_nettype wire

// *** hdl/rcd_core_decode.v ***
`timescale 1ns/1ns
`default_nettype none
`include "rcd_consts.vh"

module rcd_core_decode (
   input wire clk,
   input wire reset_n,
   output reg [10:0] pc_reg,
   input wire [13:0] instr_in,
   output reg [6:0] file_addr_reg,
   output reg file_rd_en_reg,
   input wire [7:0] file_rd_data,
   output reg file_wr_en_reg,
   output reg [7:0] file_wr_data_reg,
   input wire [7:0] port_pins,
   input wire prescaler_to_timer,
   output reg prescaler_clear_reg,
   output reg stack_push_reg,
   output reg [10:0] stack_push_addr_reg,
   output reg stack_pop_reg,
   input wire [10:0] stack_top,
   output reg int_enable_set_reg,
   output reg sleep_req_reg,
   output reg wdt_clear_reg,
   output reg flush_cycle_reg,
   output reg [7:0] w_reg,
   output reg carry_flag_reg,
   output reg nibble_carry_flag_reg,
   output reg zero_flag_reg,
   output reg watchdog_expiry_flag_reg,
   output reg sleep_entered_flag_reg
);
   wire [1:0] phase;
   wire cycle_end;
   reg [13:0] instr_reg;
   reg [7:0] operand_reg;
   reg [7:0] pin_meta_reg;
   reg [7:0] pin_sync_reg;

   wire [1:0] group;
   wire [3:0] byte_op;
   wire dest;
   wire [6:0] faddr;
   wire [2:0] bit_sel;
   wire [1:0] bit_op;
   wire [7:0] lit8;
   wire [10:0] lit11;
   wire [3:0] lit_op;
   wire is_jump;

   rcd_qphase u_qphase (
      .clk(clk),
      .reset_n(reset_n),
      .phase(phase),
      .cycle_end(cycle_end)
   );

   rcd_field_split u_split (
      .instr(instr_reg),
      .group(group),
      .byte_op(byte_op),
      .dest(dest),
      .file_addr(faddr),
      .bit_sel(bit_sel),
      .bit_op(bit_op),
      .lit8(lit8),
      .lit11(lit11),
      .lit_op(lit_op),
      .is_jump(is_jump)
   );

   // shared adder: W+f, f-W, W+k, k-W
   wire lit_grp = (group == `RCD_GRP_LITCTL);
   wire do_sub = lit_grp ? (lit_op[3:1] == 3'h6) : (byte_op == `RCD_OP_SUBWF);
   wire [7:0] add_a = lit_grp ? lit8 : operand_reg;
   wire [7:0] add_b = do_sub ? ~w_reg : w_reg;
   wire [8:0] add_sum = {1'b0, add_a} + {1'b0, add_b} + {8'h00, do_sub};
   wire [4:0] add_nib = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, do_sub};
   wire [7:0] bit_mask = 8'h01 << bit_sel;
   wire [6:0] misc_code = instr_reg[6:0];

   reg file_named;
   reg [7:0] res;
   reg wr_f;
   reg wr_w;
   reg upd_c;
   reg upd_nc;
   reg upd_z;
   reg c_next;
   reg nc_next;
   reg skip;
   reg load_pc;
   reg [10:0] pc_target;
   reg push;
   reg pop;
   reg retfie;
   reg sleep_op;
   reg wdt_op;

   always @* begin
      file_named = 1'b0;
      res = operand_reg;
      wr_f = 1'b0;
      wr_w = 1'b0;
      upd_c = 1'b0;
      upd_nc = 1'b0;
      upd_z = 1'b0;
      c_next = carry_flag_reg;
      nc_next = nibble_carry_flag_reg;
      skip = 1'b0;
      load_pc = 1'b0;
      pc_target = lit11;
      push = 1'b0;
      pop = 1'b0;
      retfie = 1'b0;
      sleep_op = 1'b0;
      wdt_op = 1'b0;
      case (group)
         `RCD_GRP_BYTE: begin
            // CLRW and the misc d=0 forms name no file register
            file_named = dest | ((byte_op != `RCD_OP_MISC) && (byte_op != `RCD_OP_CLR));
            wr_f = dest;
            wr_w = ~dest;
            case (byte_op)
               `RCD_OP_MISC: begin
                  wr_w = 1'b0;
                  res = w_reg;
                  if (!dest) begin
                     // bits 6:0 of the misc forms are decoded exactly; any other d=0 code acts as a no-op
                     case (misc_code)
                        `RCD_MISC_RETURN: begin
                           pop = 1'b1;
                           load_pc = 1'b1;
                           pc_target = stack_top;
                        end
                        `RCD_MISC_RETFIE: begin
                           pop = 1'b1;
                           retfie = 1'b1;
                           load_pc = 1'b1;
                           pc_target = stack_top;
                        end
                        `RCD_MISC_SLEEP: sleep_op = 1'b1;
                        `RCD_MISC_CLRWDT: wdt_op = 1'b1;
                        default: sleep_op = 1'b0;
                     endcase
                  end
               end
               `RCD_OP_CLR: begin
                  res = 8'h00;
                  upd_z = 1'b1;
               end
               `RCD_OP_SUBWF, `RCD_OP_ADDWF: begin
                  res = add_sum[7:0];
                  upd_c = 1'b1;
                  upd_nc = 1'b1;
                  upd_z = 1'b1;
                  c_next = add_sum[8];
                  nc_next = add_nib[4];
               end
               `RCD_OP_DECF: begin
                  res = operand_reg - 8'h01;
                  upd_z = 1'b1;
               end
               `RCD_OP_IORWF: begin
                  res = operand_reg | w_reg;
                  upd_z = 1'b1;
               end
               `RCD_OP_ANDWF: begin
                  res = operand_reg & w_reg;
                  upd_z = 1'b1;
               end
               `RCD_OP_XORWF: begin
                  res = operand_reg ^ w_reg;
                  upd_z = 1'b1;
               end
               `RCD_OP_MOVF: upd_z = 1'b1;
               `RCD_OP_COMF: begin
                  res = ~operand_reg;
                  upd_z = 1'b1;
               end
               `RCD_OP_INCF: begin
                  res = operand_reg + 8'h01;
                  upd_z = 1'b1;
               end
               `RCD_OP_DECFSZ: begin
                  res = operand_reg - 8'h01;
                  skip = (res == 8'h00);
               end
               `RCD_OP_INCFSZ: begin
                  res = operand_reg + 8'h01;
                  skip = (res == 8'h00);
               end
               `RCD_OP_RRF: begin
                  res = {carry_flag_reg, operand_reg[7:1]};
                  upd_c = 1'b1;
                  c_next = operand_reg[0];
               end
               `RCD_OP_RLF: begin
                  res = {operand_reg[6:0], carry_flag_reg};
                  upd_c = 1'b1;
                  c_next = operand_reg[7];
               end
               default: res = {operand_reg[3:0], operand_reg[7:4]};
            endcase
         end
         `RCD_GRP_BIT: begin
            file_named = 1'b1;
            case (bit_op)
               `RCD_BOP_CLR: begin
                  res = operand_reg & ~bit_mask;
                  wr_f = 1'b1;
               end
               `RCD_BOP_SET: begin
                  res = operand_reg | bit_mask;
                  wr_f = 1'b1;
               end
               `RCD_BOP_TSTC: skip = ((operand_reg & bit_mask) == 8'h00);
               default: skip = ((operand_reg & bit_mask) != 8'h00);
            endcase
         end
         default: begin
            if (is_jump) begin
               load_pc = 1'b1;
               push = ~instr_reg[11];
            end else begin
               wr_w = 1'b1;
               res = lit8;
               // low bits of MOVLW, RETLW, SUBLW and ADDLW codes are don't-care
               casez (lit_op)
                  4'b00??: res = lit8;
                  4'b01??: begin
                     pop = 1'b1;
                     load_pc = 1'b1;
                     pc_target = stack_top;
                  end
                  `RCD_LOP_IORLW: begin
                     res = lit8 | w_reg;
                     upd_z = 1'b1;
                  end
                  `RCD_LOP_ANDLW: begin
                     res = lit8 & w_reg;
                     upd_z = 1'b1;
                  end
                  `RCD_LOP_XORLW: begin
                     res = lit8 ^ w_reg;
                     upd_z = 1'b1;
                  end
                  `RCD_LOP_UNDEF: wr_w = 1'b0;
                  default: begin
                     res = add_sum[7:0];
                     upd_c = 1'b1;
                     upd_nc = 1'b1;
                     upd_z = 1'b1;
                     c_next = add_sum[8];
                     nc_next = add_nib[4];
                  end
               endcase
            end
         end
      endcase
   end

   // port pins are asynchronous to clk
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta_reg <= 8'h00;
         pin_sync_reg <= 8'h00;
      end else begin
         pin_meta_reg <= port_pins;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_reg <= `RCD_PC_RST;
         instr_reg <= `RCD_INSTR_RST;
         operand_reg <= 8'h00;
         file_addr_reg <= 7'h00;
         file_rd_en_reg <= 1'b0;
         file_wr_en_reg <= 1'b0;
         file_wr_data_reg <= 8'h00;
         prescaler_clear_reg <= 1'b0;
         stack_push_reg <= 1'b0;
         stack_push_addr_reg <= `RCD_PC_RST;
         stack_pop_reg <= 1'b0;
         int_enable_set_reg <= 1'b0;
         sleep_req_reg <= 1'b0;
         wdt_clear_reg <= 1'b0;
         flush_cycle_reg <= 1'b0;
         w_reg <= `RCD_W_RST;
         carry_flag_reg <= 1'b0;
         nibble_carry_flag_reg <= 1'b0;
         zero_flag_reg <= 1'b0;
         watchdog_expiry_flag_reg <= 1'b1;
         sleep_entered_flag_reg <= 1'b1;
      end else begin
         file_rd_en_reg <= 1'b0;
         file_wr_en_reg <= 1'b0;
         prescaler_clear_reg <= 1'b0;
         stack_push_reg <= 1'b0;
         stack_pop_reg <= 1'b0;
         int_enable_set_reg <= 1'b0;
         sleep_req_reg <= 1'b0;
         wdt_clear_reg <= 1'b0;
         case (phase)
            `RCD_PH_Q1: begin
               if (!flush_cycle_reg) begin
                  instr_reg <= instr_in;
               end
            end
            `RCD_PH_Q2: begin
               // read even for write-only ops; a port read also clears pin-change state
               if (!flush_cycle_reg && file_named) begin
                  file_addr_reg <= faddr;
                  file_rd_en_reg <= 1'b1;
               end
            end
            `RCD_PH_Q3: begin
               if (faddr == `RCD_ADDR_IO_PORT) begin
                  operand_reg <= pin_sync_reg;
               end else begin
                  operand_reg <= file_rd_data;
               end
            end
            default: begin
               if (cycle_end && flush_cycle_reg) begin
                  flush_cycle_reg <= 1'b0;
               end else if (cycle_end) begin
                  flush_cycle_reg <= skip | load_pc;
                  if (load_pc) begin
                     pc_reg <= pc_target;
                  end else if (skip) begin
                     pc_reg <= pc_reg + 11'h002;
                  end else begin
                     pc_reg <= pc_reg + 11'h001;
                  end
                  if (wr_f) begin
                     file_addr_reg <= faddr;
                     file_wr_en_reg <= 1'b1;
                     file_wr_data_reg <= res;
                     prescaler_clear_reg <= (faddr == `RCD_ADDR_TIMER_ZERO) & prescaler_to_timer;
                  end
                  if (wr_w) begin
                     w_reg <= res;
                  end
                  // flags move only for ops defined to touch them
                  if (upd_c) begin
                     carry_flag_reg <= c_next;
                  end
                  if (upd_nc) begin
                     nibble_carry_flag_reg <= nc_next;
                  end
                  if (upd_z) begin
                     zero_flag_reg <= (res == 8'h00);
                  end
                  if (sleep_op | wdt_op) begin
                     watchdog_expiry_flag_reg <= 1'b1;
                     sleep_entered_flag_reg <= wdt_op;
                  end
                  sleep_req_reg <= sleep_op;
                  wdt_clear_reg <= wdt_op;
                  stack_push_reg <= push;
                  stack_push_addr_reg <= pc_reg + 11'h001;
                  stack_pop_reg <= pop;
                  int_enable_set_reg <= retfie;
               end
            end
         endcase
      end
   end
endmodule

`default_nettype wire

// *** dv/rcd_core_decode_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module rcd_core_decode_properties (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [10:0] pc_reg,
   input wire logic [13:0] instr_in,
   input wire logic [6:0] file_addr_reg,
   input wire logic file_rd_en_reg,
   input wire logic file_wr_en_reg,
   input wire logic prescaler_to_timer,
   input wire logic prescaler_clear_reg,
   input wire logic stack_push_reg,
   input wire logic [10:0] stack_push_addr_reg,
   input wire logic stack_pop_reg,
   input wire logic sleep_req_reg,
   input wire logic wdt_clear_reg,
   input wire logic flush_cycle_reg,
   input wire logic watchdog_expiry_flag_reg,
   input wire logic sleep_entered_flag_reg
);
   wire logic [10:0] k11;
   assign k11 = instr_in[10:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   rd_before_wr_a: assert property (file_wr_en_reg |-> $past(file_rd_en_reg, 2))
      else $error("write without read two clocks before");
   same_addr_a: assert property (file_wr_en_reg |-> file_addr_reg == $past(file_addr_reg, 2))
      else $error("write address differs from read address");
   rd_spacing_a: assert property (file_rd_en_reg |=> !file_rd_en_reg [*3])
      else $error("read strobes closer than one instruction cycle");
   flush_len_a: assert property ($rose(flush_cycle_reg) |-> flush_cycle_reg [*4] ##1 !flush_cycle_reg)
      else $error("dead cycle not four clocks");
   flush_quiet_a: assert property (flush_cycle_reg && $past(flush_cycle_reg) |->
      !file_rd_en_reg && !file_wr_en_reg && $stable(pc_reg))
      else $error("activity during dead cycle");
   call_flush_a: assert property (stack_push_reg |-> flush_cycle_reg && pc_reg == $past(k11, 3))
      else $error("call target or dead cycle wrong");
   ret_addr_a: assert property (stack_push_reg |-> stack_push_addr_reg == $past(pc_reg) + 11'h001)
      else $error("return address wrong");
   psc_only_a: assert property (prescaler_clear_reg |-> file_wr_en_reg && file_addr_reg == 7'h01)
      else $error("prescaler clear without timer write");
   psc_must_a: assert property (file_wr_en_reg && file_addr_reg == 7'h01 && prescaler_to_timer
      && $past(prescaler_to_timer) |-> prescaler_clear_reg)
      else $error("timer write left prescaler");
   sleep_flags_a: assert property (sleep_req_reg |-> watchdog_expiry_flag_reg && !sleep_entered_flag_reg)
      else $error("sleep flags wrong");
   wdt_flags_a: assert property (wdt_clear_reg |-> watchdog_expiry_flag_reg && sleep_entered_flag_reg)
      else $error("watchdog clear flags wrong");
   cover property ($rose(flush_cycle_reg));
   cover property (stack_pop_reg);
   cover property (prescaler_clear_reg);
   cover property (sleep_req_reg);
endmodule
bind rcd_core_decode rcd_core_decode_properties chk (.clk(clk), .reset_n(reset_n), .pc_reg(pc_reg),
   .instr_in(instr_in), .file_addr_reg(file_addr_reg), .file_rd_en_reg(file_rd_en_reg),
   .file_wr_en_reg(file_wr_en_reg), .prescaler_to_timer(prescaler_to_timer),
   .prescaler_clear_reg(prescaler_clear_reg), .stack_push_reg(stack_push_reg),
   .stack_push_addr_reg(stack_push_addr_reg), .stack_pop_reg(stack_pop_reg), .sleep_req_reg(sleep_req_reg),
   .wdt_clear_reg(wdt_clear_reg), .flush_cycle_reg(flush_cycle_reg),
   .watchdog_expiry_flag_reg(watchdog_expiry_flag_reg), .sleep_entered_flag_reg(sleep_entered_flag_reg));
`default_nettype wire

// *** dv/rcd_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rcd_mem_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [10:0] pc_reg,
   output logic [13:0] instr_in,
   input wire logic [6:0] file_addr_reg,
   input wire logic file_rd_en_reg,
   output logic [7:0] file_rd_data,
   input wire logic file_wr_en_reg,
   input wire logic [7:0] file_wr_data_reg,
   input wire logic stack_push_reg,
   input wire logic [10:0] stack_push_addr_reg,
   input wire logic stack_pop_reg,
   output logic [10:0] stack_top
);
   logic [13:0] rom [0:7];
   logic [7:0] fr [0:127];
   logic [10:0] stk [0:7];
   logic [2:0] sp;
   logic pcif;
   // words past the loaded image fetch as no-ops
   assign instr_in = (pc_reg < 11'h008) ? rom[pc_reg[2:0]] : 14'h0000;
   // port address returns the latch, so pin levels must come from elsewhere; unselected reads show garbage
   assign file_rd_data = file_rd_en_reg ? fr[file_addr_reg] : ~fr[file_addr_reg];
   assign stack_top = stk[sp - 3'h1];
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sp <= 3'h0;
      end else if (stack_push_reg) begin
         stk[sp] <= stack_push_addr_reg;
         sp <= sp + 3'h1;
      end else if (stack_pop_reg) begin
         sp <= sp - 3'h1;
      end
   end
   always @(posedge clk) begin
      if (file_wr_en_reg)
         fr[file_addr_reg] <= file_wr_data_reg;
      if (file_rd_en_reg && file_addr_reg == 7'h06)
         pcif <= 1'b0;
   end
endmodule
`default_nettype wire

// *** dv/tb_risc_core_instruction_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_risc_core_instruction_decode;
   logic clk, reset_n, prescaler_to_timer, file_rd_en_reg, file_wr_en_reg, prescaler_clear_reg;
   logic stack_push_reg, stack_pop_reg, int_enable_set_reg, sleep_req_reg, wdt_clear_reg, flush_cycle_reg;
   logic carry_flag_reg, nibble_carry_flag_reg, zero_flag_reg, watchdog_expiry_flag_reg, sleep_entered_flag_reg;
   logic [10:0] pc_reg, stack_push_addr_reg, stack_top;
   logic [13:0] instr_in;
   logic [6:0] file_addr_reg;
   logic [7:0] file_rd_data, file_wr_data_reg, port_pins, w_reg;
   int error_cnt, total_checks, psc_n, ie_n;
   rcd_core_decode dut (.clk(clk), .reset_n(reset_n), .pc_reg(pc_reg), .instr_in(instr_in),
      .file_addr_reg(file_addr_reg), .file_rd_en_reg(file_rd_en_reg), .file_rd_data(file_rd_data),
      .file_wr_en_reg(file_wr_en_reg), .file_wr_data_reg(file_wr_data_reg), .port_pins(port_pins),
      .prescaler_to_timer(prescaler_to_timer), .prescaler_clear_reg(prescaler_clear_reg),
      .stack_push_reg(stack_push_reg), .stack_push_addr_reg(stack_push_addr_reg), .stack_pop_reg(stack_pop_reg),
      .stack_top(stack_top), .int_enable_set_reg(int_enable_set_reg), .sleep_req_reg(sleep_req_reg),
      .wdt_clear_reg(wdt_clear_reg), .flush_cycle_reg(flush_cycle_reg), .w_reg(w_reg),
      .carry_flag_reg(carry_flag_reg), .nibble_carry_flag_reg(nibble_carry_flag_reg),
      .zero_flag_reg(zero_flag_reg), .watchdog_expiry_flag_reg(watchdog_expiry_flag_reg),
      .sleep_entered_flag_reg(sleep_entered_flag_reg));
   rcd_mem_model pm (.clk(clk), .reset_n(reset_n), .pc_reg(pc_reg), .instr_in(instr_in),
      .file_addr_reg(file_addr_reg), .file_rd_en_reg(file_rd_en_reg), .file_rd_data(file_rd_data),
      .file_wr_en_reg(file_wr_en_reg), .file_wr_data_reg(file_wr_data_reg), .stack_push_reg(stack_push_reg),
      .stack_push_addr_reg(stack_push_addr_reg), .stack_pop_reg(stack_pop_reg), .stack_top(stack_top));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (prescaler_clear_reg === 1'b1)
         psc_n++;
      if (int_enable_set_reg === 1'b1)
         ie_n++;
   end
   task wrap_up;
      if (error_cnt == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task load(input logic [7:0][13:0] p);
      for (int i = 0; i < 8; i++)
         pm.rom[i] = p[7 - i];
   endtask
   // each program ends in a jump to itself, so reaching that address marks completion
   task run(input logic [10:0] last, output int n);
      @(posedge clk);
      #1 reset_n = 1'b0;
      repeat (20) @(posedge clk);
      #1 reset_n = 1'b1;
      n = 0;
      while (pc_reg !== last && n < 400) begin
         @(posedge clk);
         #1 n++;
      end
      chk_bit(pc_reg === last, 1'b1);
      repeat (2) @(posedge clk);
      #1;
   endtask
   task t_byte_dest;
      int n;
      prescaler_to_timer = 1'b0;
      load({14'h3005, 14'h00ff, 14'h077f, 14'h07ff, 14'h2804, 14'h0000, 14'h0000, 14'h0000});
      run(11'h004, n);
      chk_byte(w_reg, 8'h0a);
      chk_byte(pm.fr[127], 8'h0f);
   endtask
   task t_flow;
      int n;
      pm.fr[32] = 8'h00;
      load({14'h3000, 14'h15a0, 14'h1da0, 14'h30ee, 14'h2006, 14'h2805, 14'h345a, 14'h0000});
      run(11'h005, n);
      chk_byte(8'(n), 8'h1c);
      chk_byte(w_reg, 8'h5a);
      chk_byte(pm.fr[32], 8'h08);
   endtask
   task t_port;
      int n;
      // leading no-op gives the pin synchroniser its two clocks
      port_pins = 8'ha5;
      prescaler_to_timer = 1'b1;
      pm.fr[6] = 8'h3c;
      pm.pcif = 1'b1;
      psc_n = 0;
      load({14'h0000, 14'h0806, 14'h0186, 14'h0081, 14'h2804, 14'h0000, 14'h0000, 14'h0000});
      run(11'h004, n);
      chk_byte(w_reg, 8'ha5);
      chk_byte(pm.fr[6], 8'h00);
      chk_bit(pm.pcif, 1'b0);
      chk_byte(pm.fr[1], 8'ha5);
      chk_byte(8'(psc_n), 8'h01);
   endtask
   task t_flags;
      int n;
      prescaler_to_timer = 1'b0;
      load({14'h0064, 14'h0063, 14'h33ff, 14'h3f01, 14'h3b55, 14'h3310, 14'h2806, 14'h0000});
      run(11'h006, n);
      chk_byte(w_reg, 8'h10);
      chk_bit(carry_flag_reg, 1'b1);
      chk_bit(nibble_carry_flag_reg, 1'b1);
      chk_bit(zero_flag_reg, 1'b1);
      chk_bit(watchdog_expiry_flag_reg, 1'b1);
      chk_bit(sleep_entered_flag_reg, 1'b0);
   endtask
   // return and return-from-interrupt each reload pc from the stack and cost a dead cycle
   task t_ret;
      int n;
      ie_n = 0;
      load({14'h2003, 14'h2004, 14'h2802, 14'h0008, 14'h0009, 14'h0000, 14'h0000, 14'h0000});
      run(11'h002, n);
      chk_byte(8'(n), 8'h1c);
      chk_byte(8'(ie_n), 8'h01);
      chk_byte(8'(pm.sp), 8'h00);
   endtask
   initial begin
      error_cnt = 0;
      total_checks = 0;
      psc_n = 0;
      ie_n = 0;
      reset_n = 1'b0;
      port_pins = 8'h00;
      prescaler_to_timer = 1'b0;
      t_byte_dest;
      t_flow;
      t_port;
      t_flags;
      t_ret;
      wrap_up;
   end
   // whole run is well under a thousand clocks
   initial begin
      #20000;
      error_cnt++;
      wrap_up;
   end
endmodule
`default_nettype wire
